// ### design/power_mode_pkg.sv
// Package for the power-mode controller: register addresses, field positions,
// reset values, prescale encodings and the external bus carrier.
// Assumes a byte-wide special-register port driven by the processor core.
package power_mode_pkg;

  // Register addresses on the special-register port.
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] CLOCK_CONTROL_0_ADDR = 8'hf9;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_0_RESET = 8'h50;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Power control register fields.
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int TX_CLK1_BIT = 2;
  localparam int RX_CLK1_BIT = 3;
  localparam int COLD_BIT = 4;
  localparam int RSVD_BIT = 5;
  localparam int BAUD1_BIT = 6;
  localparam int BAUD0_BIT = 7;

  // Clock control register 0 fields.
  localparam int PS_LSB = 0;
  localparam int PS_MSB = 2;
  localparam int AUTO_REC_BIT = 3;
  localparam logic [2:0] PS_FULL = 3'h0;

  // Core restart delay after a supervisor reset, in machine cycles.
  localparam int RESTART_MACH_CYCLES = 3;
  localparam int CLKS_PER_MACH_CYCLE = 4;

  // Idle bus levels.
  localparam logic [7:0] BUS_IDLE_BYTE = 8'hff;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10
  } power_mode_t;

  typedef struct packed {
    logic ale;
    logic program_fetch_strobe_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr_data_low;
    logic [7:0] addr_high;
  } ext_bus_t;

endpackage

// ### design/power_mode_ctrl.sv
// Power-mode controller: idle, power-down and reduced core frequency.
// Assumes a same-clock special-register port from the core, same-clock
// interrupt and supervisor reset requests, and an asynchronous reset pin.
//
// Contract
// - Idle stops only the core and watchdog clocks
// - Peripherals keep running during idle
// - Idle bit write is last instruction
// - Idle preserves all core and register state
// - Enabled interrupt clears idle bit, resumes
// - Supervisor reset ends idle, restart after three
// - Watchdog inactive in idle; other resets work
// - Port outputs held in low power
// - Power-down bit write is last instruction
// - Power-down stops oscillator and all clocks
// - Power-down retains registers and memories
// - Only supervisor resets end power-down
// - Bus pins parked in low power
// - Three-bit prescaler divides core clock
// - Prescale encodings one to 2048
// - Prescaler affects core and watchdog only
// - Auto recovery clears prescale on interrupt
// - Auto recovery bit 3, prescale 2:0
// - Power control register layout and reset
// - Cold flag set by power-on or by a register write of one
`timescale 1ns/1ps

module power_mode_ctrl #(
  parameter int MACH_CYCLE_CLKS = power_mode_pkg::CLKS_PER_MACH_CYCLE
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic irq_in,
  input wire logic ext_reset_n_in,
  input wire logic lvd_reset_in,
  input wire logic debug_reset_in,
  input wire logic watchdog_reset_in,
  input wire logic power_on_reset_in,
  input wire power_mode_pkg::ext_bus_t core_bus_in,
  output power_mode_pkg::ext_bus_t bus_out,
  output logic core_clk_en_out,
  output logic watchdog_clk_en_out,
  output logic peripheral_clk_en_out,
  output logic usb_clk_en_out,
  output logic osc_en_out,
  output logic port_hold_out,
  output logic core_reset_out
);

  localparam int RESTART_CLKS = power_mode_pkg::RESTART_MACH_CYCLES * MACH_CYCLE_CLKS;

  function automatic logic [10:0] div_last(input logic [2:0] ps);
    case (ps)
      3'h0: div_last = 11'h000;
      3'h1: div_last = 11'h001;
      3'h2: div_last = 11'h003;
      3'h3: div_last = 11'h007;
      3'h4: div_last = 11'h00f;
      3'h5: div_last = 11'h01f;
      3'h6: div_last = 11'h3ff;
      default: div_last = 11'h7ff;
    endcase
  endfunction

  logic [7:0] power_control_register_q;
  logic [7:0] clock_control_0_q;
  logic [2:0] pin_sync_q;
  logic pin_reset_q;
  logic [10:0] div_cnt_q;
  logic tick;
  logic [7:0] restart_q;
  logic idle_req;
  logic pdown_req;
  logic halted;
  logic warm_reset;
  logic power_control_wr;
  logic ccon_wr;
  power_mode_pkg::power_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources

  // The pin is asynchronous; it counts only once two late stages agree.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync_q <= 3'h7;
      pin_reset_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], ext_reset_n_in};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_reset_q <= ~pin_sync_q[2];
      end
    end
  end

  assign idle_req = power_control_register_q[power_mode_pkg::IDLE_BIT];
  assign pdown_req = power_control_register_q[power_mode_pkg::PDOWN_BIT];

  always_comb begin
    if (pdown_req) begin
      mode = power_mode_pkg::MODE_PDOWN;
    end else if (idle_req) begin
      mode = power_mode_pkg::MODE_IDLE;
    end else begin
      mode = power_mode_pkg::MODE_RUN;
    end
  end

  assign warm_reset = pin_reset_q | lvd_reset_in | debug_reset_in |
                      (watchdog_reset_in & (mode == power_mode_pkg::MODE_RUN));

  assign halted = (mode != power_mode_pkg::MODE_RUN) || (restart_q != 8'h00);

  assign power_control_wr = sfr_wr_in && !halted && (sfr_addr_in == power_mode_pkg::POWER_CONTROL_ADDR);
  assign ccon_wr = sfr_wr_in && !halted && (sfr_addr_in == power_mode_pkg::CLOCK_CONTROL_0_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Power control register

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_control_register_q <= power_mode_pkg::POWER_CONTROL_RESET;
    end else begin
      if (power_control_wr) begin
        power_control_register_q <= sfr_wdata_in;
        power_control_register_q[power_mode_pkg::RSVD_BIT] <= 1'b0;
      end else if (warm_reset) begin
        power_control_register_q[power_mode_pkg::IDLE_BIT] <= 1'b0;
        power_control_register_q[power_mode_pkg::PDOWN_BIT] <= 1'b0;
      end else if (irq_in && mode == power_mode_pkg::MODE_IDLE) begin
        power_control_register_q[power_mode_pkg::IDLE_BIT] <= 1'b0;
      end
      if (power_on_reset_in) begin
        power_control_register_q[power_mode_pkg::COLD_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock control register 0

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clock_control_0_q <= power_mode_pkg::CLOCK_CONTROL_0_RESET;
    end else if (irq_in && mode != power_mode_pkg::MODE_PDOWN &&
                 (ccon_wr ? sfr_wdata_in[power_mode_pkg::AUTO_REC_BIT]
                          : clock_control_0_q[power_mode_pkg::AUTO_REC_BIT])) begin
      clock_control_0_q <= ccon_wr ? sfr_wdata_in : clock_control_0_q;
      clock_control_0_q[power_mode_pkg::PS_MSB:power_mode_pkg::PS_LSB] <=
        power_mode_pkg::PS_FULL;
    end else if (ccon_wr) begin
      clock_control_0_q <= sfr_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= power_mode_pkg::READ_UNMAPPED;
    end else if (sfr_rd_in && sfr_addr_in == power_mode_pkg::POWER_CONTROL_ADDR) begin
      sfr_rdata_out <= power_control_register_q;
    end else if (sfr_rd_in && sfr_addr_in == power_mode_pkg::CLOCK_CONTROL_0_ADDR) begin
      sfr_rdata_out <= clock_control_0_q;
    end else begin
      sfr_rdata_out <= power_mode_pkg::READ_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock prescaler

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_q <= 11'h000;
    end else if (div_cnt_q >= div_last(clock_control_0_q[2:0])) begin
      div_cnt_q <= 11'h000;
    end else begin
      div_cnt_q <= div_cnt_q + 11'h001;
    end
  end

  assign tick = (div_cnt_q >= div_last(clock_control_0_q[2:0]));

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      restart_q <= 8'h00;
    end else if (warm_reset) begin
      restart_q <= 8'(RESTART_CLKS);
    end else if (restart_q != 8'h00) begin
      restart_q <= restart_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates and pin holding

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_clk_en_out <= 1'b0;
      watchdog_clk_en_out <= 1'b0;
      peripheral_clk_en_out <= 1'b1;
      usb_clk_en_out <= 1'b1;
      osc_en_out <= 1'b1;
      port_hold_out <= 1'b0;
      core_reset_out <= 1'b0;
    end else begin
      // prescale only core and watchdog
      // A supervisor reset in run must not let one more core pulse through.
      core_clk_en_out <= tick && !halted && !warm_reset;
      watchdog_clk_en_out <= tick && (mode == power_mode_pkg::MODE_RUN);
      peripheral_clk_en_out <= (mode != power_mode_pkg::MODE_PDOWN);
      usb_clk_en_out <= (mode != power_mode_pkg::MODE_PDOWN);
      osc_en_out <= (mode != power_mode_pkg::MODE_PDOWN);
      port_hold_out <= (mode != power_mode_pkg::MODE_RUN);
      core_reset_out <= warm_reset || (restart_q > 8'h01);
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_out <= '{1'b0, 1'b1, 1'b1, 1'b1, 8'hff, 8'hff};
    end else if (mode != power_mode_pkg::MODE_RUN) begin
      bus_out <= '{1'b0, 1'b1, 1'b1, 1'b1, power_mode_pkg::BUS_IDLE_BYTE,
                   power_mode_pkg::BUS_IDLE_BYTE};
    end else begin
      bus_out <= core_bus_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_idle_core_off;
    @(posedge mclk_in) disable iff (!rstn_in)
      (mode == power_mode_pkg::MODE_IDLE) |=> !core_clk_en_out && peripheral_clk_en_out;
  endproperty
  a_idle_core_off: assert property (p_idle_core_off) else $error("core clock ran in idle");

  property p_idle_entry;
    @(posedge mclk_in) disable iff (!rstn_in)
      (power_control_wr && sfr_wdata_in[0] && !sfr_wdata_in[1]) |=> idle_req ##1 !core_clk_en_out;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_irq_wake;
    @(posedge mclk_in) disable iff (!rstn_in)
      (mode == power_mode_pkg::MODE_IDLE && irq_in && !power_control_wr) |=> !idle_req;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not end idle");

  property p_restart;
    @(posedge mclk_in) disable iff (!rstn_in)
      (warm_reset && !power_control_wr) |=> !idle_req && !pdown_req ##0 !core_clk_en_out [*2];
  endproperty
  a_restart: assert property (p_restart) else $error("reset did not restart core");

  property p_wdt_idle;
    @(posedge mclk_in) disable iff (!rstn_in)
      (mode == power_mode_pkg::MODE_IDLE) |=> !watchdog_clk_en_out;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog clocked in idle");

  property p_pdown_off;
    @(posedge mclk_in) disable iff (!rstn_in)
      pdown_req |=> !osc_en_out && !usb_clk_en_out && !peripheral_clk_en_out && port_hold_out;
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("clocks ran in power-down");

  property p_pdown_stay;
    @(posedge mclk_in) disable iff (!rstn_in)
      (pdown_req && !warm_reset && !power_control_wr) |=> pdown_req;
  endproperty
  a_pdown_stay: assert property (p_pdown_stay) else $error("power-down left early");

  property p_bus_park;
    @(posedge mclk_in) disable iff (!rstn_in)
      (idle_req || pdown_req) |=> !bus_out.ale && bus_out.rd_n &&
        bus_out.addr_data_low == 8'hff && bus_out.addr_high == 8'hff;
  endproperty
  a_bus_park: assert property (p_bus_park) else $error("bus not parked");

  property p_auto_rec;
    @(posedge mclk_in) disable iff (!rstn_in)
      (irq_in && !pdown_req && clock_control_0_q[3] && !ccon_wr) |=>
        clock_control_0_q[2:0] == 3'h0;
  endproperty
  a_auto_rec: assert property (p_auto_rec) else $error("prescale not restored");

  property p_cold;
    @(posedge mclk_in) disable iff (!rstn_in)
      power_on_reset_in |=> power_control_register_q[4];
  endproperty
  a_cold: assert property (p_cold) else $error("cold flag not set");

endmodule

// ### test/core_model.sv
// Model of the processor core, interrupt sources and supervisor resets.
// Assumes the bench calls its tasks; outputs move only at falling edges.
`timescale 1ns/1ps
module core_model (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic irq_out,
  output logic ext_reset_n_out,
  output logic lvd_out,
  output logic debug_out,
  output logic watchdog_out,
  output logic por_out,
  output power_mode_pkg::ext_bus_t bus_out
);
  initial begin
    {wr_out, rd_out, irq_out, lvd_out, debug_out, watchdog_out, por_out} = 7'h00;
    ext_reset_n_out = 1'b1;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // The core bus changes every cycle so that a stale copy cannot pass.
  always @(negedge clk_in) bus_out <= power_mode_pkg::ext_bus_t'(20'($urandom));
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = w;
    rd_out = ~w;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // Random writes, interrupts, watchdog and power-on pulses; a halted block must ignore all but the power-on cold flag.
  task automatic noise(input int c);
    repeat (c) begin
      @(negedge clk_in);
      {wr_out, irq_out, watchdog_out, por_out} = 4'($urandom);
      addr_out = 8'($urandom);
      wdata_out = 8'($urandom);
    end
    @(negedge clk_in);
    {wr_out, irq_out, watchdog_out, por_out} = 4'h0;
  endtask
  task automatic pulse(input int k);
    @(negedge clk_in);
    case (k)
      0: irq_out = 1'b1;
      1: lvd_out = 1'b1;
      2: debug_out = 1'b1;
      3: watchdog_out = 1'b1;
      4: por_out = 1'b1;
      default: ext_reset_n_out = 1'b0;
    endcase
    repeat ((k == 5) ? 4 : 1) @(negedge clk_in);
    {irq_out, lvd_out, debug_out, watchdog_out, por_out} = 5'h00;
    ext_reset_n_out = 1'b1;
  endtask
endmodule

// ### test/tb_mcu_power_mode_control.sv
// Self-checking bench for the power-mode controller.
// Assumes core_model drives all inputs except clock and reset.
`timescale 1ns/1ps
module tb_mcu_power_mode_control;
  localparam int M = 2;
  localparam logic [7:0] PC = power_mode_pkg::POWER_CONTROL_ADDR;
  localparam logic [7:0] CC = power_mode_pkg::CLOCK_CONTROL_0_ADDR;
  localparam logic [19:0] PARK = 20'h7ffff;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic wr, rd, irq, ext_n, low_voltage_detect, dbg, wdt, por, rd_q;
  logic core_en, wdt_en, per_en, usb_en, osc_en, hold, core_rst;
  logic [7:0] addr, wdata, rdata, v;
  power_mode_pkg::ext_bus_t core_bus, bus_o, bus_last;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int n;
  int divs[8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};
  power_mode_ctrl #(.MACH_CYCLE_CLKS(M)) i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .irq_in(irq), .ext_reset_n_in(ext_n), .lvd_reset_in(low_voltage_detect),
    .debug_reset_in(dbg), .watchdog_reset_in(wdt), .power_on_reset_in(por),
    .core_bus_in(core_bus), .bus_out(bus_o), .core_clk_en_out(core_en),
    .watchdog_clk_en_out(wdt_en), .peripheral_clk_en_out(per_en),
    .usb_clk_en_out(usb_en), .osc_en_out(osc_en), .port_hold_out(hold),
    .core_reset_out(core_rst));
  core_model i_core (.clk_in(mclk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .irq_out(irq), .ext_reset_n_out(ext_n), .lvd_out(low_voltage_detect),
    .debug_out(dbg), .watchdog_out(wdt), .por_out(por), .bus_out(core_bus));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic results();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Read data is compared against the oldest queued note in its valid cycle.
  always @(posedge mclk_in) begin
    rd_q <= rd;
    bus_last <= core_bus;
  end
  always @(negedge mclk_in) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else chk(32'(exp_q.pop_front()), 32'(rdata));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_in);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_core.access(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_core.access(1'b0, a, 8'h00);
  endtask
  function automatic logic [31:0] st();
    return 32'({osc_en, per_en, usb_en, hold, wdt_en, core_en});
  endfunction
  task automatic wait_on(input int lim);
    n = 0;
    while (core_en !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic meas(input int div);
    wait_on(2100);
    n = 0;
    do begin
      cyc(1);
      n++;
      chk(32'(core_en), 32'(wdt_en));
      chk(32'h1, 32'(per_en));
    end while (core_en !== 1'b1 && n < 2100);
    chk(32'(div), 32'(n));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(60000);
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(50));
    cyc(10);
    chk(32'(PARK), 32'(bus_o));
    rstn_in = 1'b1;
    rd_reg(PC, 8'h00);
    rd_reg(CC, 8'h50);
    rd_reg(8'h42, power_mode_pkg::READ_UNMAPPED);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & 8'hec;
      wr_reg(PC, v);
      rd_reg(PC, v & 8'hcc);
    end
    wr_reg(PC, 8'h00);
    i_core.pulse(4);
    rd_reg(PC, 8'h10);
    wr_reg(PC, 8'h00);
    rd_reg(PC, 8'h00);
    for (int p = 0; p < 8; p++) begin
      wr_reg(CC, 8'h50 | 8'(p));
      meas(divs[p]);
    end
    wr_reg(CC, 8'h5e);
    i_core.pulse(0);
    rd_reg(CC, 8'h58);
    wr_reg(CC, 8'h56);
    i_core.pulse(0);
    rd_reg(CC, 8'h56);
    wr_reg(CC, 8'h40);
    wr_reg(PC, 8'h01);
    cyc(2);
    chk(32'h3c, st());
    chk(32'(PARK), 32'(bus_o));
    i_core.pulse(3);
    wr_reg(PC, 8'h40);
    cyc(2);
    chk(32'h3c, st());
    i_core.pulse(0);
    cyc(2);
    chk(32'(bus_last), 32'(bus_o));
    rd_reg(PC, 8'h00);
    wr_reg(PC, 8'h01);
    cyc(2);
    i_core.pulse(1);
    cyc(1);
    chk(32'h1, 32'(core_rst));
    wait_on(100);
    chk(32'h1, 32'(n >= 3 * M && n <= 3 * M + 1));
    rd_reg(PC, 8'h00);
    i_core.pulse(3);
    chk(32'h1, 32'(core_rst));
    wait_on(100);
    wr_reg(PC, 8'hc3);
    cyc(2);
    chk(32'h04, st());
    chk(32'(PARK), 32'(bus_o));
    i_core.pulse(0);
    i_core.pulse(3);
    i_core.noise(16);
    i_core.pulse(4);
    cyc(2);
    chk(32'h04, st());
    i_core.pulse(2);
    wait_on(40);
    rd_reg(PC, 8'hd0);
    wr_reg(PC, 8'h02);
    cyc(2);
    chk(32'h04, st());
    i_core.pulse(5);
    wait_on(40);
    chk(32'h1, 32'(osc_en));
    rd_reg(PC, 8'h00);
    cyc(3);
    results();
  end
endmodule
